// File: design/nic_pkg.sv
// Behaviour
// - Priority held in condition code bits 5,3
// - Levels 0..3 encode as 10,01,00,11
// - Finish instruction, then stack PC,X,A,CC
// - Entry loads priority bits from vector setting
// - Fourteen vectors plus trap, reset at FFE0h-FFFFh
// - Return pops context including priority bits
// - Highest software level, then highest hardware order
// - Unserved requests stay latched until they win
// - Reset and trap outrank level 3
// - Non-maskable: stack (not reset), vector, level 3
// - Reset and trap leave halt mode
// - Trap instruction raises the trap event
// - Serve only enabled, higher-than-current requests
// - Edge external request cleared on entry
// - Enabled pins of one line are ORed
// - Peripheral request needs flag and enable
// - Flag clear sequence drops pending latch
// - All wake wait; only capable sources wake halt
// - After halt, first service is halt-capable
// - Level changed by rim/sim/halt/wfi/return_from_interrupt/pop
// - Watchdog flag bit 0, software clears, rest zero
// - Condition code resets with level 3
// - Writing level 0 to a pair is ignored
// - Four priority registers reset to ones, top nibble fixed
package nic_pkg;
  localparam int        NVEC       = 14;           // Maskable vectors
  localparam int        NPIN       = 16;           // External pins, four per line
  localparam int        NLINE      = 4;            // External lines
  localparam int        EXT_FIRST  = 2;            // Vector of the first external line
  localparam int        I1_POS     = 5;            // High priority bit in condition code
  localparam int        I0_POS     = 3;            // Low priority bit in condition code
  localparam int        WDG_POS    = 0;            // Watchdog flag position
  localparam logic [7:0]  CC_RESET   = 8'hea;      // Level 3 after reset
  localparam logic [7:0]  ISPR_RESET = 8'hff;      // All vectors at level 3
  localparam logic [3:0]  ISPR3_RO   = 4'hf;       // Fixed upper nibble of last priority register
  localparam logic [1:0]  LVL0       = 2'b10;      // Main level encoding
  localparam logic [1:0]  LVL1       = 2'b01;
  localparam logic [1:0]  LVL3       = 2'b11;      // Interrupts disabled
  localparam logic [15:0] VEC_TOP0   = 16'hfffa;   // Vector 0, highest hardware order
  localparam logic [15:0] VEC_TRAP   = 16'hfffc;
  localparam logic [15:0] VEC_RESET  = 16'hfffe;
  localparam logic [13:0] EXT_MASK   = 14'h003c;   // Vectors fed by external lines
  localparam logic [13:0] HALT_CAP   = 14'h00be;   // Vectors that may leave halt
  localparam logic [2:0]  CTX_BYTES  = 3'd5;       // Bytes stacked per interrupt
  // Register indexes on the plain register port
  localparam logic [2:0]  REG_CC     = 3'h0;
  localparam logic [2:0]  REG_ISPR0  = 3'h1;
  localparam logic [2:0]  REG_ISPR3  = 3'h4;
  localparam logic [2:0]  REG_SIFLAG = 3'h5;

  // Instruction events reported by the core, one-cycle pulses
  typedef struct packed {
    logic       instr_end;  // Current instruction completes
    logic       trap;       // Software trap executed
    logic       return_from_interrupt;       // Return from interrupt executed
    logic       enable_interrupts_instr;        // Enable interrupts instruction
    logic       sim;        // Disable interrupts instruction
    logic       halt;       // Enter halt
    logic       wait_for_interrupt_instr;        // Enter wait
    logic       pop_cc;     // Condition code popped by software
    logic [7:0] cc_data;    // Value for pop_cc
  } nic_cpu_ev_t;

  // Core context that is stacked on entry
  typedef struct packed {
    logic [15:0] pc;
    logic [7:0]  x;
    logic [7:0]  a;
  } nic_ctx_t;

  // Stack memory strobes
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } nic_stk_t;
endpackage

// File: design/nic_ctrl.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module nic_ctrl (
  input  wire logic                clk,
  input  wire logic                arst_n,
  input  wire logic [2:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic [7:0]               reg_rdata,
  input  wire nic_pkg::nic_cpu_ev_t cpu_ev,
  input  wire nic_pkg::nic_ctx_t   ctx_in,
  input  wire logic [7:0]          stk_rdata,
  output nic_pkg::nic_stk_t        stk_out,
  output logic                     pc_load,
  output logic [15:0]              pc_addr,
  output logic                     ctx_restore,
  output nic_pkg::nic_ctx_t        ctx_out,
  output logic [7:0]               cc_out,
  output logic                     wake,
  output logic                     busy,
  input  wire logic [13:0]         periph_flag,
  input  wire logic [13:0]         periph_en,
  input  wire logic [13:0]         periph_clr,
  input  wire logic [15:0]         ext_pin,
  input  wire logic [15:0]         ext_pin_sel,
  input  wire logic                wdg_reset_evt
);
  import nic_pkg::*;

  typedef enum logic [2:0] {ST_RESET, ST_IDLE, ST_PUSH, ST_VECT, ST_POP} nic_state_t;

  // Map a priority pair onto a rank 0..3, so levels compare as numbers
  function automatic logic [1:0] rank(input logic [1:0] p);
    rank = {p[1] ~^ p[0], p[0]};
  endfunction

  nic_state_t  state_reg;             // Sequencer state
  logic [2:0]  cnt_reg;               // Byte counter for stack moves
  logic [7:0]  cc_reg;                // Condition code, priority bits inside
  logic [7:0]  ispr_reg [4];          // Per-vector priority pairs
  logic [7:0]  sif_reg;               // Integrity flags
  logic [13:0] pend_reg;              // Latched maskable requests
  logic        trap_pend_reg;         // Trap waiting for the next boundary
  logic        halt_reg;              // Core is halted
  logic        wait_reg;              // Core is waiting
  logic        halt_exit_reg;         // First service after halt is restricted
  logic        svc_trap_reg;          // Service in progress is the trap
  logic [3:0]  svc_idx_reg;           // Maskable vector being entered
  logic [1:0]  svc_lvl_reg;           // Level to load on entry
  logic [15:0] pin_s1_reg, pin_s2_reg, pin_s3_reg, pin_st_reg; // Pin synchroniser
  logic [3:0]  line_reg;              // Previous line levels for edges
  logic [7:0]  rdata_reg;
  nic_stk_t    stk_reg;
  logic        pc_load_reg;
  logic [15:0] pc_addr_reg;
  logic        rest_reg;
  nic_ctx_t    ctx_reg;               // Popped context
  logic        wake_reg;
  logic        busy_reg;              // Sequencer not idle, a flop so the pin never glitches

  // Priority pairs and current rank
  wire [1:0]  cur_lvl  = {cc_reg[I1_POS], cc_reg[I0_POS]};
  wire [1:0]  cur_rank = rank(cur_lvl);
  logic [1:0] vec_lvl [NVEC];
  for (genvar v = 0; v < NVEC; v++) begin : g_lvl
    assign vec_lvl[v] = ispr_reg[v / 4][2 * (v % 4) +: 2];
  end

  // Pin filter: a pin change counts once stages two and three agree
  wire [15:0] pin_agree = ~(pin_s2_reg ^ pin_s3_reg);
  wire [15:0] pin_st_next = (pin_agree & pin_s3_reg) | (~pin_agree & pin_st_reg);
  wire [15:0] pin_on = pin_st_reg & ext_pin_sel;
  logic [3:0] line_lvl;
  for (genvar g = 0; g < NLINE; g++) begin : g_line
    assign line_lvl[g] = |pin_on[4 * g +: 4];
  end
  wire [3:0] line_edge = line_lvl & ~line_reg;

  // Request sources: level for peripherals, rising edge for external lines
  wire [13:0] ext_set   = {8'h00, line_edge, 2'b00} & EXT_MASK;
  wire [13:0] per_set   = periph_flag & periph_en & ~EXT_MASK;
  wire [13:0] entry_clr = (state_reg == ST_VECT && !svc_trap_reg) ?
                          (EXT_MASK & (14'h0001 << svc_idx_reg)) : 14'h0000;
  wire [13:0] pend_next = (pend_reg & ~((periph_clr & ~EXT_MASK) | entry_clr)) | ext_set | per_set;

  // Eligibility: pending, above current level, halt-capable right after halt
  wire [13:0] halt_gate = halt_exit_reg ? HALT_CAP : 14'h3fff;
  logic [13:0] elig;
  for (genvar v = 0; v < NVEC; v++) begin : g_elig
    assign elig[v] = pend_reg[v] && halt_gate[v] && (rank(vec_lvl[v]) > cur_rank);
  end

  // Arbiter: scan from lowest hardware order so ties go to lower index
  logic [3:0] win_idx;
  logic [1:0] win_rank;
  logic       win_valid;
  always_comb begin
    win_idx   = 4'h0;
    win_rank  = 2'b00;
    win_valid = 1'b0;
    for (int v = NVEC - 1; v >= 0; v--) begin
      if (elig[v] && (!win_valid || rank(vec_lvl[v]) >= win_rank)) begin
        win_idx   = 4'(v);
        win_rank  = rank(vec_lvl[v]);
        win_valid = 1'b1;
      end
    end
  end

  wire take     = (state_reg == ST_IDLE) && cpu_ev.instr_end && (trap_pend_reg || win_valid);
  wire take_return_from_interrupt = (state_reg == ST_IDLE) && cpu_ev.return_from_interrupt && !take;
  wire [15:0] vec_addr = VEC_TOP0 - {11'h000, svc_idx_reg, 1'b0};

  // Sequencer next state
  nic_state_t state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_RESET: state_next = ST_IDLE;
      ST_IDLE:  state_next = take ? ST_PUSH : (take_return_from_interrupt ? ST_POP : ST_IDLE);
      ST_PUSH:  state_next = (cnt_reg == CTX_BYTES - 3'd1) ? ST_VECT : ST_PUSH;
      ST_VECT:  state_next = ST_IDLE;
      ST_POP:   state_next = (cnt_reg == CTX_BYTES) ? ST_IDLE : ST_POP;
    endcase
  end
  wire [2:0] cnt_next = (state_reg != state_next) ? 3'd0 : cnt_reg + 3'd1;

  // Bytes go out low PC first and come back in reverse
  logic [7:0] push_byte;
  always_comb begin
    unique case (cnt_reg)
      3'd0:    push_byte = ctx_in.pc[7:0];
      3'd1:    push_byte = ctx_in.pc[15:8];
      3'd2:    push_byte = ctx_in.x;
      3'd3:    push_byte = ctx_in.a;
      default: push_byte = cc_reg;
    endcase
  end
  wire pop_cap = (state_reg == ST_POP) && (cnt_reg != 3'd0);
  wire [2:0] pop_idx = cnt_reg - 3'd1;

  // Condition code: entry wins, then pop, then instructions, then bus
  wire [1:0] entry_lvl = svc_trap_reg ? LVL3 : svc_lvl_reg;
  logic [7:0] cc_next;
  always_comb begin
    cc_next = cc_reg;
    if (state_reg == ST_VECT) begin
      cc_next[I1_POS] = entry_lvl[1];
      cc_next[I0_POS] = entry_lvl[0];
    end else if (pop_cap && pop_idx == 3'd0) begin
      cc_next = stk_rdata;
    end else if (cpu_ev.pop_cc) begin
      cc_next = cpu_ev.cc_data;
    end else if (cpu_ev.sim) begin
      {cc_next[I1_POS], cc_next[I0_POS]} = LVL3;
    end else if (cpu_ev.enable_interrupts_instr || cpu_ev.halt || cpu_ev.wait_for_interrupt_instr) begin
      {cc_next[I1_POS], cc_next[I0_POS]} = LVL0;
    end else if (reg_wr && reg_addr == REG_CC) begin
      cc_next = reg_wdata;
    end
  end

  // Priority register writes keep any pair written as level 0
  function automatic logic [7:0] ispr_merge(input logic [7:0] old, input logic [7:0] nw);
    ispr_merge = nw;
    for (int p = 0; p < 4; p++) begin
      if (nw[2 * p +: 2] == LVL0) ispr_merge[2 * p +: 2] = old[2 * p +: 2];
    end
  endfunction

  // Read decode
  wire [2:0] ispr_sel = reg_addr - REG_ISPR0;
  wire       is_ispr  = reg_addr >= REG_ISPR0 && reg_addr <= REG_ISPR3;
  wire [7:0] rd_mux   = (reg_addr == REG_CC)     ? cc_reg :
                        is_ispr                  ? ispr_reg[ispr_sel[1:0]] :
                        (reg_addr == REG_SIFLAG) ? sif_reg : 8'h00;

  // Watchdog flag: event sets, written zero clears, set wins
  wire sif_clr = reg_wr && reg_addr == REG_SIFLAG && !reg_wdata[WDG_POS];
  wire wdg_next = wdg_reset_evt || (sif_reg[WDG_POS] && !sif_clr);

  // Wake: any request leaves wait, only capable ones leave halt
  wire any_req  = |pend_reg || trap_pend_reg;
  wire halt_req = |(pend_reg & HALT_CAP) || trap_pend_reg;
  wire wake_now = (wait_reg && any_req) || (halt_reg && halt_req);

  // Sequencer and counters
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_RESET;
      cnt_reg   <= 3'd0;
      busy_reg  <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      busy_reg  <= (state_next != ST_IDLE);
    end
  end

  // Condition code and programmable registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cc_reg  <= CC_RESET;
      ispr_reg <= '{default: ISPR_RESET};
      sif_reg <= 8'h00;
    end else begin
      cc_reg <= cc_next;
      if (reg_wr && is_ispr) begin
        ispr_reg[ispr_sel[1:0]] <= ispr_merge(ispr_reg[ispr_sel[1:0]], reg_wdata);
        if (reg_addr == REG_ISPR3) begin
          ispr_reg[3][7:4] <= ISPR3_RO;
        end
      end
      sif_reg <= {7'h00, wdg_next};
    end
  end

  // Pending latches, service capture, low-power state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pend_reg      <= 14'h0000;
      trap_pend_reg <= 1'b0;
      svc_trap_reg  <= 1'b0;
      svc_idx_reg   <= 4'h0;
      svc_lvl_reg   <= LVL3;
      halt_reg      <= 1'b0;
      wait_reg      <= 1'b0;
      halt_exit_reg <= 1'b0;
      wake_reg      <= 1'b0;
    end else begin
      pend_reg      <= pend_next;
      trap_pend_reg <= cpu_ev.trap || (trap_pend_reg && !(state_reg == ST_VECT && svc_trap_reg));
      if (take) begin
        svc_trap_reg <= trap_pend_reg;
        svc_idx_reg  <= win_idx;
        svc_lvl_reg  <= vec_lvl[win_idx];
      end
      halt_reg      <= cpu_ev.halt || (halt_reg && !wake_now);
      wait_reg      <= cpu_ev.wait_for_interrupt_instr || (wait_reg && !wake_now);
      halt_exit_reg <= (halt_reg && wake_now) || (halt_exit_reg && !take);
      wake_reg      <= wake_now;
    end
  end

  // Pin synchroniser and line edge memory
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= 16'h0000;
      pin_s2_reg <= 16'h0000;
      pin_s3_reg <= 16'h0000;
      pin_st_reg <= 16'h0000;
      line_reg   <= 4'h0;
    end else begin
      pin_s1_reg <= ext_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      pin_st_reg <= pin_st_next;
      line_reg   <= line_lvl;
    end
  end

  // Core-facing strobes, all registered
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stk_reg     <= '0;
      pc_load_reg <= 1'b0;
      pc_addr_reg <= VEC_RESET;
      rest_reg    <= 1'b0;
      ctx_reg     <= '0;
      rdata_reg   <= 8'h00;
    end else begin
      stk_reg.wr    <= (state_reg == ST_PUSH);
      stk_reg.wdata <= push_byte;
      stk_reg.rd    <= (state_reg == ST_POP) && (cnt_reg < CTX_BYTES);
      pc_load_reg   <= 1'b0;
      rest_reg      <= 1'b0;
      if (state_reg == ST_RESET) begin
        pc_load_reg <= 1'b1;
        pc_addr_reg <= VEC_RESET;
      end else if (state_reg == ST_VECT) begin
        pc_load_reg <= 1'b1;
        pc_addr_reg <= svc_trap_reg ? VEC_TRAP : vec_addr;
      end else if (pop_cap) begin
        unique case (pop_idx)
          3'd1:    ctx_reg.a        <= stk_rdata;
          3'd2:    ctx_reg.x        <= stk_rdata;
          3'd3:    ctx_reg.pc[15:8] <= stk_rdata;
          3'd4: begin
            ctx_reg.pc[7:0] <= stk_rdata;
            pc_load_reg     <= 1'b1;
            pc_addr_reg     <= {ctx_reg.pc[15:8], stk_rdata};
            rest_reg        <= 1'b1;
          end
          default: ;
        endcase
      end
      rdata_reg <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata   = rdata_reg;
  assign stk_out     = stk_reg;
  assign pc_load     = pc_load_reg;
  assign pc_addr     = pc_addr_reg;
  assign ctx_restore = rest_reg;
  assign ctx_out     = ctx_reg;
  assign cc_out      = cc_reg;
  assign wake        = wake_reg;
  assign busy        = busy_reg;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_trap_lvl3: assert property (state_reg == ST_VECT && svc_trap_reg |=> cc_reg[I1_POS] && cc_reg[I0_POS])
    else $error("trap entry did not set level 3");
  a_entry_lvl: assert property (state_reg == ST_VECT && !svc_trap_reg |=> cur_lvl == $past(svc_lvl_reg))
    else $error("entry level not loaded");
  a_push_five: assert property (take |=> !stk_reg.wr ##1 stk_reg.wr[*5] ##1 (!stk_reg.wr && pc_load_reg))
    else $error("context push not five bytes before vector");
  a_win_above: assert property (take && !trap_pend_reg |-> rank(vec_lvl[win_idx]) > cur_rank)
    else $error("served a request not above current level");
  a_ext_clear: assert property (state_reg == ST_VECT && !svc_trap_reg && EXT_MASK[svc_idx_reg] && !ext_set[svc_idx_reg]
                                |=> !pend_reg[$past(svc_idx_reg)])
    else $error("external request not cleared on entry");
  a_wdg_set: assert property (wdg_reset_evt |=> sif_reg[WDG_POS] ##1 (sif_reg[WDG_POS] || $past(sif_clr)))
    else $error("watchdog flag lost");
  a_rsvd_zero: assert property (sif_reg[7:1] == 7'h00 && ispr_reg[3][7:4] == ISPR3_RO)
    else $error("reserved bits not fixed");
  a_halt_first: assert property (take && halt_exit_reg && !trap_pend_reg |-> HALT_CAP[win_idx])
    else $error("first service after halt not halt-capable");
  a_sim_lvl3: assert property (cpu_ev.sim && state_reg == ST_IDLE && !pop_cap && !cpu_ev.pop_cc |=> cur_lvl == LVL3)
    else $error("disable instruction did not set level 3");

  c_nested: cover property (take && !trap_pend_reg && cur_rank != 2'd0);
  c_trap:   cover property (take && trap_pend_reg);
  c_return_from_interrupt:   cover property (rest_reg);
  c_halt:   cover property (halt_reg && wake_now);
endmodule

// File: bench/nic_stack_model.sv
`timescale 1ns/1ns
// Stack memory beside the core: a byte LIFO answering in the same cycle as a read strobe
module nic_stack_model (
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire nic_pkg::nic_stk_t stk_out,
  output logic [7:0]             stk_rdata
);
  import nic_pkg::*;
  logic [7:0] mem [0:31];  // Stack bytes, wraps like the real stack
  logic [4:0] sp_reg;      // Next free place
  logic [7:0] idle_reg;    // Filler shown while not read
  // The sequencer captures the byte in the cycle its read strobe stands, so answer there
  assign stk_rdata = stk_out.rd ? mem[sp_reg - 5'd1] : idle_reg;
  // Push on write, pop on read; LIFO gives CC,A,X,PCH,PCL back in that order
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sp_reg   <= 5'h00;
      idle_reg <= 8'h5a;
    end else begin
      // Not answering: toggle so a mistimed sample never sees a stale byte
      idle_reg <= ~idle_reg;
      if (stk_out.wr) begin
        mem[sp_reg] <= stk_out.wdata;
        sp_reg      <= sp_reg + 5'd1;
      end
      if (stk_out.rd) begin
        sp_reg <= sp_reg - 5'd1;
      end
    end
  end
endmodule

// File: bench/test_nested_priority_interrupt_ctrl.sv
`timescale 1ns/1ns
module test_nested_priority_interrupt_ctrl;
  import nic_pkg::*;
  localparam int EV_END = 15;  // Bit positions inside the event struct
  localparam int EV_TRAP = 14;
  localparam int EV_RETURN_FROM_INTERRUPT = 13;
  localparam int EV_RIM = 12;
  localparam int EV_SIM = 11;
  localparam int EV_HALT = 10;
  localparam int EV_WFI = 9;
  localparam int EV_POP = 8;
  logic        clk, arst_n, reg_wr, reg_rd, pc_load, ctx_restore, wake, busy, wdg_reset_evt;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, stk_rdata, cc_out;
  logic [15:0] pc_addr, ext_pin, ext_pin_sel, last_pc;
  logic [13:0] periph_flag, periph_en, periph_clr;
  nic_cpu_ev_t cpu_ev;
  nic_ctx_t    ctx_in, ctx_out, last_ctx;
  nic_stk_t    stk_out;
  logic        last_rs;     // Restore strobe seen beside the last PC load
  int          loads;       // PC loads seen so far
  int          mismatches;
  int          compares;
  int unsigned rng = 32'd47638;
  nic_ctx_t    ctxq[$];     // Context stacked per nesting level
  logic [7:0]  ccq[$];      // Condition code expected back at return

  nic_ctrl nic_ctrl_inst (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cpu_ev(cpu_ev), .ctx_in(ctx_in),
    .stk_rdata(stk_rdata), .stk_out(stk_out), .pc_load(pc_load), .pc_addr(pc_addr),
    .ctx_restore(ctx_restore), .ctx_out(ctx_out), .cc_out(cc_out), .wake(wake), .busy(busy),
    .periph_flag(periph_flag), .periph_en(periph_en), .periph_clr(periph_clr), .ext_pin(ext_pin),
    .ext_pin_sel(ext_pin_sel), .wdg_reset_evt(wdg_reset_evt));
  nic_stack_model nic_stack_model_inst (.clk(clk), .arst_n(arst_n), .stk_out(stk_out), .stk_rdata(stk_rdata));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Record every PC load with what stood beside it
  always @(posedge clk) begin
    if (pc_load === 1'b1) begin
      loads    <= loads + 1;
      last_pc  <= pc_addr;
      last_rs  <= ctx_restore;
      last_ctx <= ctx_out;
    end
  end

  function automatic int unsigned xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [1:0] lvl(input logic [7:0] c);
    return {c[I1_POS], c[I0_POS]};
  endfunction
  // A pair written as level 0 keeps its old value; last register has a fixed top nibble
  function automatic logic [7:0] ispr_exp(input logic [7:0] old, input logic [7:0] nw, input bit top);
    logic [7:0] r;
    for (int p = 0; p < 4; p++) begin
      r[2*p+:2] = (nw[2*p+:2] == LVL0) ? old[2*p+:2] : nw[2*p+:2];
    end
    if (top) begin
      r[7:4] = ISPR3_RO;
    end
    return r;
  endfunction

  task automatic report_and_stop();
    $display("mismatches %0d compares %0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
    @(posedge clk) reg_rd <= 1'b0;
    #1;
    check("reg_rdata", exp, reg_rdata);
  endtask
  task automatic pulse(input int b, input logic [7:0] d);
    nic_cpu_ev_t t;
    t = '0;
    t[b] = 1'b1;
    t.cc_data = d;
    @(posedge clk) cpu_ev <= t;
    @(posedge clk) cpu_ev <= '0;
    #1;
  endtask
  // Bounded wait for a new PC load
  task automatic wait_load(input int n0);
    for (int k = 0; k < 30 && loads == n0; k++) begin
      @(posedge clk);
      #1;
    end
    check("pc_load", 16'(n0 + 1), 16'(loads));
  endtask
  task automatic wait_wake();
    for (int k = 0; k < 12 && wake !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    check("wake", 1'b1, wake);
  endtask
  // Instruction ends with nothing that may be taken
  task automatic none();
    int n0;
    n0 = loads;
    pulse(EV_END, 8'h00);
    repeat (12) @(posedge clk);
    #1;
    check("pc_load", 16'(n0), 16'(loads));
  endtask
  task automatic serve(input logic [15:0] exp_pc, input logic [1:0] exp_lvl);
    int n0;
    logic [4:0] sp;
    n0 = loads;
    @(posedge clk) ctx_in <= nic_ctx_t'(xs());
    #1;
    ctxq.push_back(ctx_in);
    ccq.push_back(cc_out);
    pulse(EV_END, 8'h00);
    wait_load(n0);
    sp = nic_stack_model_inst.sp_reg;
    check("vector", exp_pc, last_pc);
    check("level", exp_lvl, lvl(cc_out));
    check("stk pcl", ctx_in.pc[7:0], nic_stack_model_inst.mem[sp - 5'd5]);
    check("stk pch", ctx_in.pc[15:8], nic_stack_model_inst.mem[sp - 5'd4]);
    check("stk x a", {ctx_in.x, ctx_in.a},
          {nic_stack_model_inst.mem[sp - 5'd3], nic_stack_model_inst.mem[sp - 5'd2]});
    check("stk cc", ccq[$], nic_stack_model_inst.mem[sp - 5'd1]);
    check("busy", 1'b0, busy);
  endtask
  task automatic return_from_interrupt();
    int n0;
    nic_ctx_t c;
    n0 = loads;
    c = ctxq.pop_back();
    pulse(EV_RETURN_FROM_INTERRUPT, 8'h00);
    wait_load(n0);
    check("ret pc", c.pc, last_pc);
    check("ret x a", {c.x, c.a}, {last_ctx.x, last_ctx.a});
    check("ret cc", ccq.pop_back(), cc_out);
    check("restore", 1'b1, last_rs);
  endtask
  task automatic clr(input logic [13:0] m);
    @(posedge clk) begin periph_flag <= periph_flag & ~m; periph_clr <= m; end
    @(posedge clk) periph_clr <= '0;
  endtask

  initial begin
    #200000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    int idx;
    logic [7:0] v;
    logic [7:0] ispr [0:3];
    arst_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0; reg_rd = 1'b0; cpu_ev = '0;
    ctx_in = '0; periph_flag = '0; periph_en = 14'h37ff; periph_clr = '0; ext_pin = '0;
    ext_pin_sel = '0; wdg_reset_evt = 1'b0; loads = 0; mismatches = 0; compares = 0;
    repeat (20) @(posedge clk);
    check("cc in reset", CC_RESET, cc_out);
    check("busy in reset", 1'b1, busy);
    @(posedge clk) arst_n <= 1'b1;
    wait_load(0);
    check("reset vector", VEC_RESET, last_pc);
    rd_reg(REG_CC, CC_RESET);
    for (int i = 0; i < 4; i++) begin
      rd_reg(3'(REG_ISPR0 + i), ISPR_RESET);
    end
    rd_reg(REG_SIFLAG, 8'h00);
    rd_reg(3'h6, 8'h00);
    // Priority registers: hand corners first, then random values
    ispr = '{8'hff, 8'hff, 8'hff, 8'hff};
    for (int i = 0; i < 10; i++) begin
      idx = (i < 2) ? 0 : (i == 2) ? 3 : int'(xs() % 4);
      v = (i == 0) ? 8'hcf : (i == 1) ? 8'h64 : (i == 2) ? 8'h00 : 8'(xs());
      wr_reg(3'(REG_ISPR0 + idx), v);
      ispr[idx] = ispr_exp(ispr[idx], v, idx == 3);
      rd_reg(3'(REG_ISPR0 + idx), ispr[idx]);
    end
    // Watchdog flag: set by event, survives a write of ones, cleared by zero
    @(posedge clk) wdg_reset_evt <= 1'b1;
    @(posedge clk) wdg_reset_evt <= 1'b0;
    rd_reg(REG_SIFLAG, 8'h01);
    wr_reg(REG_SIFLAG, 8'hff);
    rd_reg(REG_SIFLAG, 8'h01);
    wr_reg(REG_SIFLAG, 8'h00);
    rd_reg(REG_SIFLAG, 8'h00);
    // Vector 3 at level 2, 4..7 level 3, 8..11 level 1
    wr_reg(REG_ISPR0, 8'h3f);
    wr_reg(3'(REG_ISPR0 + 1), 8'hff);
    wr_reg(3'(REG_ISPR0 + 2), 8'h55);
    wr_reg(REG_ISPR3, 8'hff);
    // Two peripherals at one level pending together; disabled one never wins
    @(posedge clk) periph_flag <= 14'h0b00;
    none();
    pulse(EV_RIM, 8'h00);
    check("rim level", LVL0, lvl(cc_out));
    serve(VEC_TOP0 - 16'd16, LVL1);
    @(posedge clk) periph_flag[10] <= 1'b1;
    none();
    clr(14'h0100);
    return_from_interrupt();
    serve(VEC_TOP0 - 16'd18, LVL1);
    clr(14'h0600);
    return_from_interrupt();
    none();
    // Level 3 still lets the trap in
    v = 8'(xs());
    pulse(EV_POP, v);
    check("pop level", {v[I1_POS], v[I0_POS]}, lvl(cc_out));
    pulse(EV_SIM, 8'h00);
    check("sim level", LVL3, lvl(cc_out));
    pulse(EV_TRAP, 8'h00);
    serve(VEC_TRAP, LVL3);
    return_from_interrupt();
    // External line 1 from wait; several enabled pins ORed
    @(posedge clk) ext_pin_sel <= 16'h00f0;
    pulse(EV_WFI, 8'h00);
    check("wfi level", LVL0, lvl(cc_out));
    @(posedge clk) ext_pin[6] <= 1'b1;
    wait_wake();
    serve(VEC_TOP0 - 16'd6, 2'b00);
    return_from_interrupt();
    none();
    // Drop pin 6 so pin 7 later makes a fresh edge on the ORed line
    @(posedge clk) ext_pin[6] <= 1'b0;
    // Halt: non-capable request sleeps, capable one goes first
    wr_reg(3'(REG_ISPR0 + 2), 8'h57);
    pulse(EV_HALT, 8'h00);
    @(posedge clk) periph_flag[8] <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check("halt wake", 1'b0, wake);
    @(posedge clk) ext_pin[7] <= 1'b1;
    wait_wake();
    serve(VEC_TOP0 - 16'd6, 2'b00);
    serve(VEC_TOP0 - 16'd16, LVL3);
    clr(14'h0100);
    return_from_interrupt();
    return_from_interrupt();
    // The trap alone must leave halt
    pulse(EV_HALT, 8'h00);
    pulse(EV_TRAP, 8'h00);
    wait_wake();
    report_and_stop();
  end
endmodule
